// file: core/dram_seq_consts.vh
// Constants for the DRAM ready and column-strobe sequencer
`ifndef DRAM_SEQ_CONSTS_VH
`define DRAM_SEQ_CONSTS_VH
`define ADDR_W 8
`define REF_CNT_W 8
`define TIMER_W 12
`define REF_INTERVAL 12'hc30
`define TIMER_ONE 12'h001
`define TIMER_ZERO 12'h000
`define ADDR_ZERO 8'h00
`define CNT_ONE 8'h01
`define LATE_NS 20
`define CLK_NS 5
// Late strobe threshold in clocks: 20 ns at the 5 ns clock
`define LATE_CYC 3'h4
// Refresh row-low lengths and count end points
`define REF_LEN_4CYC 2'h3
`define REF_LEN_3CYC 2'h2
`define REF_LEN_LAST 2'h1
`define REF_LEN_ZERO 2'h0
`define CAS_DLY_W 3
`define CAS_NORMAL 3'h1
`define CAS_LATE 3'h2
`define CAS_ZERO 3'h0
`define CAS_ONE 3'h1
`endif

// file: core/sync2.v
// Two-flop synchroniser for pin inputs
module sync2 (
   input wire clk,
   input wire resetn,
   input wire din,
   input wire rst_val,
   output reg dout
);
   reg meta_reg;

   // Sync reset loads the idle level of the pin
   always @(posedge clk) begin
      if (!resetn) begin
         meta_reg <= rst_val;
         dout <= rst_val;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule // sync2

// file: core/dram_ready_cas_sequencer.v
// DRAM ready and column-strobe sequencer with refresh arbitration
// Functional notes
// - Ready returns high only on a rising system clock edge.
// - No wait strap: ready rises on the edge lowering access row strobe.
// - Wait strap: ready rises first rising edge after access strobe low.
// - Wait strap, grant cycle: ready rises one edge after row strobe low.
// - Grant after refresh, early access strobe: column strobe from row strobe edge.
// - Grant after refresh, access strobe 20 ns late: column strobe one clock later.
// - Column strobe falls only after both latch and access strobe delays.
// - Wait strap: ready waits for a rising edge even if the strobe falls with clock high.
// - Both 3-cycle and 4-cycle refresh, with either wait strap setting.
// - Refresh starts from the internal timer or the external request input.
// - Wait states inserted according to the strapped configuration input.
// - Refresh versus access arbitration and cycle start on one clock edge.
// - Latch high first with refresh pending: refresh address out, refresh starts.
// - Ready driven low after latch enable when strap set or refreshing.
`include "dram_seq_consts.vh"
module dram_ready_cas_sequencer (
   input wire sys_clk,
   input wire resetn,
   input wire addr_latch_en,
   input wire access_strobe_n,
   input wire wait_state_strap,
   input wire refresh_mode_4cyc,
   input wire refresh_request_n,
   input wire [`ADDR_W-1:0] row_addr,
   input wire [`ADDR_W-1:0] col_addr,
   output reg ready,
   output reg row_strobe_n,
   output reg col_strobe_n,
   output reg refresh_active,
   output reg [`ADDR_W-1:0] memory_address_out
);
   // State codes, one-hot
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ACCESS = 5'h02;
   localparam [4:0] ST_COL = 5'h04;
   localparam [4:0] ST_REFRESH = 5'h08;
   localparam [4:0] ST_REF_END = 5'h10;

   wire ale_s;
   wire acx_n_s;
   wire wait_state_strap_s;
   wire mode4_s;
   wire ext_req_n_s;

   // Every strobe, strap and request pin passes two flops; the address buses feed the mux directly
   sync2 u_sync_ale (.clk(sys_clk), .resetn(resetn), .din(addr_latch_en),
      .rst_val(1'b0), .dout(ale_s));
   sync2 u_sync_acx (.clk(sys_clk), .resetn(resetn), .din(access_strobe_n),
      .rst_val(1'b1), .dout(acx_n_s));
   sync2 u_sync_wait_state_strap (.clk(sys_clk), .resetn(resetn), .din(wait_state_strap),
      .rst_val(1'b0), .dout(wait_state_strap_s));
   sync2 u_sync_mode (.clk(sys_clk), .resetn(resetn), .din(refresh_mode_4cyc),
      .rst_val(1'b0), .dout(mode4_s));
   sync2 u_sync_req (.clk(sys_clk), .resetn(resetn), .din(refresh_request_n),
      .rst_val(1'b1), .dout(ext_req_n_s));

   reg [4:0] state_reg;
   reg [4:0] state_next;
   reg ale_d_reg;
   reg acx_low_d_reg;
   reg [`TIMER_W-1:0] timer_reg;
   reg [`TIMER_W-1:0] timer_next;
   reg ref_pend_reg;
   reg ref_pend_next;
   reg grant_reg;
   reg grant_next;
   reg [`REF_CNT_W-1:0] ref_row_reg;
   reg [`REF_CNT_W-1:0] ref_row_next;
   reg [`CAS_DLY_W-1:0] cas_dly_reg;
   reg [`CAS_DLY_W-1:0] cas_dly_next;
   reg [`CAS_DLY_W-1:0] late_cnt_reg;
   reg [`CAS_DLY_W-1:0] late_cnt_next;
   reg [1:0] ref_len_reg;
   reg [1:0] ref_len_next;
   reg ready_next;
   reg row_next;
   reg col_next;
   reg [`ADDR_W-1:0] ma_next;

   wire ale_rise = ale_s & ~ale_d_reg;
   wire ale_fall = ~ale_s & ale_d_reg;
   wire acx_low = ~acx_n_s;
   // Grant cycle whose strobe trailed the latch by the late threshold
   wire late_grant = grant_reg & (late_cnt_reg == `LATE_CYC);
   // Internal timer or external pin may ask for refresh
   wire ref_req = (timer_reg == `TIMER_ZERO) | ~ext_req_n_s;

   // Next-state and output logic
   always @* begin
      state_next = state_reg;
      timer_next = (timer_reg == `TIMER_ZERO) ? `REF_INTERVAL : timer_reg - `TIMER_ONE;
      ref_pend_next = ref_pend_reg | ref_req;
      grant_next = grant_reg;
      ref_row_next = ref_row_reg;
      cas_dly_next = cas_dly_reg;
      late_cnt_next = late_cnt_reg;
      ref_len_next = ref_len_reg;
      ready_next = ready;
      row_next = row_strobe_n;
      col_next = col_strobe_n;
      ma_next = memory_address_out;
      // Count how long the access strobe trails the latch fall; the access
      // state leaves idle at once, so this runs in every state
      if (ale_fall) begin
         late_cnt_next = acx_low ? `CAS_ZERO : `CAS_ONE;
      end else if (!acx_low && late_cnt_reg != `LATE_CYC) begin
         late_cnt_next = late_cnt_reg + `CAS_ONE;
      end
      case (state_reg)
         ST_IDLE: begin
            row_next = 1'b1;
            col_next = 1'b1;
            if (ale_rise && ref_pend_reg && !acx_low) begin
               // Refresh wins arbitration at the cycle start
               state_next = ST_REFRESH;
               ma_next = ref_row_reg;
               ready_next = 1'b0;
               ref_len_next = mode4_s ? `REF_LEN_4CYC : `REF_LEN_3CYC;
            end else if (ale_fall) begin
               state_next = ST_ACCESS;
               ma_next = row_addr;
               // Strap set delays ready; strap clear keeps it high except on the grant cycle
               ready_next = ~wait_state_strap_s | 1'b0;
               if (!wait_state_strap_s) begin
                  ready_next = ~grant_reg;
               end
            end else begin
               ready_next = ~(wait_state_strap_s & ale_s) | ~ale_s;
            end
         end
         ST_ACCESS: begin
            row_next = 1'b0;
            // Grant cycle waits for its row strobe edge
            if (grant_reg) begin
               ready_next = ~wait_state_strap_s;
            end
            // Column delay is timed from the row strobe edge
            cas_dly_next = `CAS_NORMAL;
            state_next = ST_COL;
         end
         ST_COL: begin
            row_next = 1'b0;
            ma_next = col_addr;
            // Column strobe needs the timed delay and a low access strobe
            if (cas_dly_reg != `CAS_ZERO) begin
               cas_dly_next = cas_dly_reg - `CAS_ONE;
            end else if (acx_low && (!late_grant || acx_low_d_reg)) begin
               // A late strobe on a grant cycle costs one more clock
               col_next = 1'b0;
            end
            // With the strap set, ready rises here, on the clock edge
            if (wait_state_strap_s && acx_low) begin
               ready_next = 1'b1;
            end
            // End of access; host keeps strobe low for a full pulse
            if (acx_n_s && !col_strobe_n) begin
               state_next = ST_IDLE;
               row_next = 1'b1;
               col_next = 1'b1;
               grant_next = 1'b0;
               ready_next = 1'b1;
            end
         end
         ST_REFRESH: begin
            row_next = 1'b0;
            ref_len_next = ref_len_reg - `REF_LEN_LAST;
            if (ref_len_reg == `REF_LEN_LAST) begin
               state_next = ST_REF_END;
            end
         end
         ST_REF_END: begin
            // Refresh done: next access is the grant cycle
            row_next = 1'b1;
            ref_row_next = ref_row_reg + `CNT_ONE;
            ref_pend_next = ref_req;
            grant_next = 1'b1;
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State and output flops; sync reset to idle levels
   always @(posedge sys_clk) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         ale_d_reg <= 1'b0;
         acx_low_d_reg <= 1'b0;
         timer_reg <= `REF_INTERVAL;
         ref_pend_reg <= 1'b0;
         grant_reg <= 1'b0;
         ref_row_reg <= `ADDR_ZERO;
         cas_dly_reg <= `CAS_ZERO;
         late_cnt_reg <= `CAS_ZERO;
         ref_len_reg <= `REF_LEN_ZERO;
         ready <= 1'b1;
         row_strobe_n <= 1'b1;
         col_strobe_n <= 1'b1;
         refresh_active <= 1'b0;
         memory_address_out <= `ADDR_ZERO;
      end else begin
         state_reg <= state_next;
         ale_d_reg <= ale_s;
         acx_low_d_reg <= acx_low;
         timer_reg <= timer_next;
         ref_pend_reg <= ref_pend_next;
         grant_reg <= grant_next;
         ref_row_reg <= ref_row_next;
         cas_dly_reg <= cas_dly_next;
         late_cnt_reg <= late_cnt_next;
         ref_len_reg <= ref_len_next;
         ready <= ready_next;
         row_strobe_n <= row_next;
         col_strobe_n <= col_next;
         refresh_active <= (state_next == ST_REFRESH) | (state_next == ST_REF_END);
         memory_address_out <= ma_next;
      end
   end
endmodule // dram_ready_cas_sequencer

// file: tb/dram_seq_checker_assertions.sv
// Checker for ready, strobe and refresh sequencing at the block ports
module dram_seq_checker (
   input wire sys_clk,
   input wire resetn,
   input wire access_strobe_n,
   input wire wait_state_strap,
   input wire ready,
   input wire row_strobe_n,
   input wire col_strobe_n,
   input wire refresh_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Column strobe only inside a row strobe, and only after the access strobe
   property p_cas_order; $fell(col_strobe_n) |-> !row_strobe_n; endproperty
   a_cas_order: assert property (p_cas_order) else $error("column before row strobe");
   property p_cas_acx; $fell(col_strobe_n) |-> !$past(access_strobe_n, 2); endproperty
   a_cas_acx: assert property (p_cas_acx) else $error("column strobe before access");
   // Ready follows the strap on the row strobe edge
   // Refresh row strobes hold ready low, so only access row edges count
   property p_nostrap;
      !wait_state_strap && !refresh_active && $fell(row_strobe_n) |-> ready;
   endproperty
   a_nostrap: assert property (p_nostrap) else $error("ready low without strap");
   property p_strap_hold;
      wait_state_strap && !refresh_active && $fell(row_strobe_n) |-> !ready;
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("no wait state");
   property p_strap_rise;
      wait_state_strap && !refresh_active && $fell(row_strobe_n) |-> ##[1:12] ready;
   endproperty
   a_strap_rise: assert property (p_strap_rise) else $error("ready stuck low");
   // End of access returns everything to idle within the sync delay
   property p_release; $rose(access_strobe_n) |-> ##[1:4] (row_strobe_n && col_strobe_n && ready);
   endproperty
   a_release: assert property (p_release) else $error("strobes not released");
   // Refresh is row-only and short
   property p_ref_cas; refresh_active |-> col_strobe_n; endproperty
   a_ref_cas: assert property (p_ref_cas) else $error("column strobe in refresh");
   property p_ref_len; $rose(refresh_active) |-> ##[1:8] !refresh_active; endproperty
   a_ref_len: assert property (p_ref_len) else $error("refresh too long");
endmodule // dram_seq_checker

bind dram_ready_cas_sequencer dram_seq_checker dram_seq_checker_inst (.sys_clk(sys_clk),
   .resetn(resetn), .access_strobe_n(access_strobe_n), .wait_state_strap(wait_state_strap),
   .ready(ready), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
   .refresh_active(refresh_active));

// file: tb/host_bus_model.sv
// Processor bus model driving latch enable and access strobe
module host_bus_model (
   input wire sys_clk,
   input wire col_strobe_n,
   output logic addr_latch_en = 1'b0,
   output logic access_strobe_n = 1'b1
);
   timeunit 1ns;
   timeprecision 100ps;
   // One access; late cycles delay the strobe past the latch fall
   task automatic bus_cycle(input int late);
      int n;
      n = 0;
      @(posedge sys_clk) #1 addr_latch_en = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 addr_latch_en = 1'b0;
      // An early strobe falls together with the latch
      repeat (late) @(posedge sys_clk);
      if (late > 0) #1;
      access_strobe_n = 1'b0;
      // Strobe held until a whole column pulse has formed, bounded
      while (col_strobe_n && n < 40) begin
         @(posedge sys_clk) #1 n++;
      end
      repeat (2) @(posedge sys_clk);
      #1 access_strobe_n = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
   // Latch raised ahead of the strobe offers the slot to a pending refresh
   task automatic raise_latch;
      addr_latch_en = 1'b1;
   endtask
endmodule // host_bus_model

// file: tb/dram_ready_cas_sequencer_tb.sv
// Self-checking bench for the ready and column-strobe sequencer
`include "dram_seq_consts.vh"
module dram_ready_cas_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic wait_state_strap = 1'b0;
   logic refresh_mode_4cyc = 1'b0;
   logic refresh_request_n = 1'b1;
   logic [`ADDR_W-1:0] row_addr = 8'h5a;
   logic [`ADDR_W-1:0] col_addr = 8'ha5;
   wire addr_latch_en, access_strobe_n, ready, row_strobe_n, col_strobe_n, refresh_active;
   wire [`ADDR_W-1:0] memory_address_out;
   int n_fail = 0;
   int n_checks = 0;
   // 200 MHz system clock
   always #2.5 sys_clk = ~sys_clk;
   dram_ready_cas_sequencer dram_ready_cas_sequencer_inst (.sys_clk(sys_clk), .resetn(resetn),
      .addr_latch_en(addr_latch_en), .access_strobe_n(access_strobe_n),
      .wait_state_strap(wait_state_strap), .refresh_mode_4cyc(refresh_mode_4cyc),
      .refresh_request_n(refresh_request_n), .row_addr(row_addr), .col_addr(col_addr),
      .ready(ready), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
      .refresh_active(refresh_active), .memory_address_out(memory_address_out));
   host_bus_model host_bus_model_inst (.sys_clk(sys_clk), .col_strobe_n(col_strobe_n),
      .addr_latch_en(addr_latch_en), .access_strobe_n(access_strobe_n));
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run;
      if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Access: address mux and ready on the row edge, idle once released
   task automatic t_access(input logic strap, input int late, input logic grant);
      int n, exp_col;
      n = 0;
      // Column edge in clocks from the latch rise; a late grant adds one
      exp_col = (late > 3) ? late + 7 + int'(grant) : 10;
      @(posedge sys_clk) #1 wait_state_strap = strap;
      fork
         host_bus_model_inst.bus_cycle(late);
         begin
            while (row_strobe_n && n < 40) begin
               @(posedge sys_clk) #1 n++;
            end
            chk("row_out", memory_address_out, row_addr);
            chk("ready_at_row", {7'h00, ready}, {7'h00, ~strap});
            while (col_strobe_n && n < 80) begin
               @(posedge sys_clk) #1 n++;
            end
            chk("col_out", memory_address_out, col_addr);
            chk("col_cycle", 8'(n), 8'(exp_col));
            @(posedge sys_clk) #1 chk("ready_at_col", {7'h00, ready}, 8'h01);
         end
      join
      chk("idle", {5'h00, ready, row_strobe_n, col_strobe_n}, 8'h07);
   endtask
   // Refresh from the request pin, counting row-low cycles
   task automatic t_refresh(input logic mode, input logic [7:0] row_exp);
      int n, lo;
      n = 0;
      lo = 0;
      @(posedge sys_clk) #1 refresh_mode_4cyc = mode;
      refresh_request_n = 1'b0;
      // Request must be pending before the latch rises
      repeat (3) @(posedge sys_clk);
      #1 host_bus_model_inst.raise_latch();
      while (!refresh_active && n < 20) begin
         @(posedge sys_clk) #1 n++;
      end
      chk("ref_start", {7'h00, refresh_active}, 8'h01);
      chk("ref_addr", memory_address_out, row_exp);
      refresh_request_n = 1'b1;
      while ((refresh_active || !row_strobe_n) && n < 60) begin
         lo += !row_strobe_n;
         @(posedge sys_clk) #1 n++;
      end
      chk("ref_row_low", 8'(lo), mode ? 8'h03 : 8'h02);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 chk("reset", {4'h0, ready, row_strobe_n, col_strobe_n, refresh_active}, 8'h0e);
      resetn = 1'b1;
      repeat (3) @(posedge sys_clk);
      for (int s = 0; s < 4; s++) begin
         t_access(s[0], s[1] ? 6 : 0, 1'b0);
         t_refresh(s[1], 8'(s));
         t_access(s[0], s[0] ? 6 : 0, 1'b1);
      end
      complete_run();
   end
   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      #50000;
      n_fail++;
      complete_run();
   end
endmodule // dram_ready_cas_sequencer_tb
